// file: dv/testbench.sv
// Self-checking bench for the period timer
`timescale 1ns/1ps
module testbench;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [3:0] adr = 4'h0;
	reg rd = 1'b0;
	reg wr = 1'b0;
	reg [31:0] wdat = 32'h0;
	wire [31:0] rdata;
	wire wait_req;
	wire irq;
	reg [7:0] got;
	integer n_errors = 0;
	integer check_count = 0;
	integer n;
	integer p;
	always #12.5 clk = ~clk;
	tps_timer i_dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdata),
		.avs_waitrequest(wait_req), .irq(irq));
	task chk(input string nm, input [7:0] s, input [7:0] e);
		check_count = check_count + 1;
		if (s !== e) begin
			n_errors = n_errors + 1;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task stop_test;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Bus access held until waitrequest is sampled low
	task acc(input [3:0] a, input w, input [7:0] d);
		integer i;
		adr <= a;
		wdat <= {24'h0, d};
		wr <= w;
		rd <= !w;
		i = 0;
		@(posedge clk);
		while (wait_req !== 1'b0 && i < 50) begin
			@(posedge clk);
			i = i + 1;
		end
		got = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		if (i == 50) begin
			n_errors = n_errors + 1;
			stop_test;
		end
		@(posedge clk);
	endtask
	// Write, read back, compare
	task wrc(input string nm, input [3:0] a, input [7:0] d, input [7:0] e);
		acc(a, 1'b1, d);
		acc(a, 1'b0, 8'h00);
		chk(nm, got, e);
	endtask
	// Wait for irq, bounded
	task wirq;
		n = 0;
		while (irq !== 1'b1 && n < 500) begin
			@(posedge clk);
			n = n + 1;
		end
		if (n == 500) begin
			n_errors = n_errors + 1;
			$display("BAD irq wait exp 1 got %b", irq);
		end
	endtask
	task t_reset;
		acc(4'h3, 1'b0, 8'h00);
		chk("period", got, 8'hFF);
		acc(4'h4, 1'b0, 8'h00);
		chk("count", got, 8'h00);
		acc(4'h5, 1'b0, 8'h00);
		chk("control", got, 8'h00);
	endtask
	task t_regs;
		wrc("period", 4'h3, 8'h5A, 8'h5A);
		wrc("count", 4'h4, 8'h3C, 8'h3C);
		wrc("control", 4'h5, 8'hFF, 8'h7F);
		wrc("unmapped", 4'h7, 8'hFF, 8'h00);
		acc(4'h5, 1'b1, 8'h00);
	endtask
	// Match rate for each prescale, postscale 1:2, period 2
	task t_rate;
		wrc("core", 4'h0, 8'hC0, 8'hC0);
		wrc("enable", 4'h1, 8'h02, 8'h02);
		acc(4'h3, 1'b1, 8'h02);
		for (p = 0; p < 3; p = p + 1) begin
			acc(4'h4, 1'b1, 8'h00);
			acc(4'h2, 1'b0, 8'h00);
			acc(4'h5, 1'b1, 8'h0C | p[7:0]);
			wirq;
			chk("ticks", n >= (16 << 2 * p) && n <= (24 << 2 * p) + 12, 8'h01);
			acc(4'h5, 1'b1, 8'h00);
			acc(4'h2, 1'b0, 8'h00);
			chk("flag", got[1], 8'h01);
			acc(4'h2, 1'b0, 8'h00);
			chk("flag clr", got[1], 8'h00);
		end
	endtask
	// The timer enable and the global enable each gate the request
	task t_mask;
		acc(4'h5, 1'b1, 8'h04);
		wirq;
		acc(4'h1, 1'b1, 8'h00);
		chk("irq pie", irq, 8'h00);
		acc(4'h1, 1'b1, 8'h02);
		wirq;
		chk("irq on", irq, 8'h01);
		acc(4'h0, 1'b1, 8'h40);
		chk("irq gie", irq, 8'h00);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_regs;
		t_rate;
		t_mask;
		stop_test;
	end
endmodule // testbench

// file: dv/tps_timer_asserts.sv
// Concurrent checks on the period timer bus and interrupt ports
`timescale 1ns/1ps
`include "tps_defines.vh"
module tps_timer_chk (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Bus and interrupt
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire irq
);
	// One domain, so one clock and one reset for all
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Write being taken; a gating bit dropped by it must silence irq
	wire cut = avs_write && avs_waitrequest && avs_byteenable[0];
	// Answered read, the moment read data values are judged; a_read_hold checks stability between reads
	wire ans = avs_read && !avs_waitrequest;
	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("answer without request");
	a_wait_bound: assert property ((avs_read || avs_write) && avs_waitrequest
		|-> ##[1:2] !avs_waitrequest)
		else $error("request not answered");
	a_read_upper: assert property (ans |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_ctl_top: assert property (ans && avs_address == `TPS_ADDR_CONTROL |-> !avs_readdata[7])
		else $error("control top bit set");
	a_bad_addr: assert property (ans && avs_address > 4'h5 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	a_gie_cut: assert property (cut && avs_address == 4'h0 && !avs_writedata[7] |-> ##3 !irq)
		else $error("irq without global enable");
	a_pie_cut: assert property (cut && avs_address == 4'h1 && !avs_writedata[1] |-> ##3 !irq)
		else $error("irq without timer enable");
	// Main scenarios reached
	c_read: cover property (ans);
	c_irq: cover property ($rose(irq));
	c_ctl: cover property (cut && avs_address == `TPS_ADDR_CONTROL);
endmodule // tps_timer_chk
bind tps_timer tps_timer_chk i_chk (.clk, .rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq);

// file: rtl/tps_defines.vh
// Register offsets, field positions, reset values and timing constants for the period timer
`ifndef TPS_DEFINES_VH
`define TPS_DEFINES_VH
// Word addresses of the registers
`define TPS_ADDR_CORE_IRQ 4'h0
`define TPS_ADDR_PIE_ONE 4'h1
`define TPS_ADDR_PIR_ONE 4'h2
`define TPS_ADDR_PERIOD 4'h3
`define TPS_ADDR_COUNT 4'h4
`define TPS_ADDR_CONTROL 4'h5
// Control register fields
`define TPS_CTL_POST_HI 6
`define TPS_CTL_POST_LO 3
`define TPS_CTL_ON 2
`define TPS_CTL_PRE_HI 1
`define TPS_CTL_PRE_LO 0
`define TPS_CTL_MASK 8'h7F
// Interrupt bit positions
`define TPS_BIT_TIMER_IRQ 1
`define TPS_BIT_GIE 7
`define TPS_BIT_PERIPHERAL_IRQ_ENABLE 6
// Reset values
`define TPS_RST_COUNT 8'h00
`define TPS_RST_PERIOD 8'hFF
`define TPS_RST_CONTROL 8'h00
// Instruction rate is one quarter of the system clock
`define TPS_INSTR_DIV 2'h3
`endif

// file: rtl/tps_prescaler.v
// Instruction-rate enable and selectable prescaler for the period timer
`timescale 1ns/1ps
module tps_prescaler (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Control
	input wire clear,
	input wire run,
	input wire [1:0] select,
	// Output enable pulse
	output reg tick
);
	`include "tps_defines.vh"
	reg [1:0] phase_reg; // Oscillator phase within the instruction cycle
	reg [3:0] pre_reg; // Prescale count
	reg [3:0] limit; // Last prescale count for the select value
	wire instr_en; // One cycle in four

	// Divide select: 1, 4, or 16 when the upper bit is set
	always @* begin
		if (select[1]) begin
			limit = 4'hF;
		end else if (select[0]) begin
			limit = 4'h3;
		end else begin
			limit = 4'h0;
		end
	end

	assign instr_en = (phase_reg == `TPS_INSTR_DIV);

	// Free-running instruction phase, then the prescale counter
	always @(posedge clk) begin
		if (rst) begin
			phase_reg <= 2'h0;
			pre_reg <= 4'h0;
			tick <= 1'b0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			tick <= 1'b0;
			if (clear) begin
				pre_reg <= 4'h0;
			end else if (run && instr_en) begin
				if (pre_reg >= limit) begin
					pre_reg <= 4'h0;
					tick <= 1'b1;
				end else begin
					pre_reg <= pre_reg + 4'h1;
				end
			end
		end
	end
endmodule // tps_prescaler

// file: rtl/tps_timer.v
// Period timer with prescaler, postscaler and Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Readable, writable 8-bit count register
// - Writable period register compared with count
// - Timer-on bit starts and stops counting
// - Top control bit reads zero; reset zero
// - Timer flag at bit 1 of flags
// - Timer enable at bit 1 of enables
// - Count increments from zero up to period
// - Match clears count, advances postscaler; postscaler output sets flag
// - Count or control write clears scalers
// - Reset: count zero, period all ones
module tps_timer (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Avalon-MM slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// Interrupt
	output reg irq
);
	// Offsets and field positions must be known here whatever the compile order
	`include "tps_defines.vh"
	reg [7:0] core_irq_reg; // Global and peripheral enables plus other bits
	reg [7:0] pie_one_reg; // Peripheral enable bits
	reg [7:0] pir_one_reg; // Peripheral flag bits
	reg [7:0] period_reg; // Match value
	reg [7:0] count_reg; // Current count
	reg [7:0] control_reg; // Postscale, on bit, prescale
	reg [3:0] post_reg; // Postscale match count
	reg done_reg; // Access answered, release one cycle
	reg [7:0] count_next; // Next count value
	reg [3:0] post_next; // Next postscale count
	reg post_fire; // Postscaler output pulse
	reg [7:0] rd_next; // Read mux
	wire tick; // Prescaler output pulse
	wire access; // Request pending this cycle
	wire wr_lane0; // Write with low byte enabled
	wire wr_count; // Software write to count
	wire wr_control; // Software write to control
	wire scaler_clear; // Clear both scalers
	wire rd_flags; // Read of the flag register

	assign access = (avs_read || avs_write) && !done_reg;
	assign wr_lane0 = access && avs_write && avs_byteenable[0];
	assign wr_count = wr_lane0 && (avs_address == `TPS_ADDR_COUNT);
	assign wr_control = wr_lane0 && (avs_address == `TPS_ADDR_CONTROL);
	assign scaler_clear = wr_count || wr_control;
	assign rd_flags = access && avs_read && (avs_address == `TPS_ADDR_PIR_ONE);

	// Prescale count holds while the timer is off; the instruction phase keeps running
	tps_prescaler u_pre (
		.clk(clk),
		.rst(rst),
		.clear(scaler_clear),
		.run(control_reg[`TPS_CTL_ON]),
		.select(control_reg[`TPS_CTL_PRE_HI:`TPS_CTL_PRE_LO]),
		.tick(tick)
	);

	// Count and postscale next values
	always @* begin
		count_next = count_reg;
		post_next = post_reg;
		post_fire = 1'b0;
		if (tick) begin
			if (count_reg == period_reg) begin
				count_next = 8'h00;
				if (post_reg >= control_reg[`TPS_CTL_POST_HI:`TPS_CTL_POST_LO]) begin
					post_next = 4'h0;
					post_fire = 1'b1;
				end else begin
					post_next = post_reg + 4'h1;
				end
			end else begin
				count_next = count_reg + 8'h01;
			end
		end
	end

	// Read data selection; unmapped addresses read zero
	always @* begin
		case (avs_address)
			`TPS_ADDR_CORE_IRQ: rd_next = core_irq_reg;
			`TPS_ADDR_PIE_ONE: rd_next = pie_one_reg;
			`TPS_ADDR_PIR_ONE: rd_next = pir_one_reg;
			`TPS_ADDR_PERIOD: rd_next = period_reg;
			`TPS_ADDR_COUNT: rd_next = count_reg;
			`TPS_ADDR_CONTROL: rd_next = control_reg & `TPS_CTL_MASK;
			default: rd_next = 8'h00;
		endcase
	end

	// Registers, bus handshake and interrupt output
	always @(posedge clk) begin
		if (rst) begin
			core_irq_reg <= 8'h00;
			pie_one_reg <= 8'h00;
			pir_one_reg <= 8'h00;
			period_reg <= `TPS_RST_PERIOD;
			count_reg <= `TPS_RST_COUNT;
			control_reg <= `TPS_RST_CONTROL;
			post_reg <= 4'h0;
			done_reg <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			avs_waitrequest <= 1'b1;
			irq <= 1'b0;
		end else begin
			done_reg <= access;
			avs_waitrequest <= !access;
			if (access && avs_read) begin
				avs_readdata <= {24'h000000, rd_next};
			end
			// Count: software write wins over the increment
			if (wr_count) begin
				count_reg <= avs_writedata[7:0];
			end else begin
				count_reg <= count_next;
			end
			// Scaler clear on count or control write
			if (scaler_clear) begin
				post_reg <= 4'h0;
			end else begin
				post_reg <= post_next;
			end
			if (wr_lane0 && avs_address == `TPS_ADDR_PERIOD) begin
				period_reg <= avs_writedata[7:0];
			end
			if (wr_control) begin
				control_reg <= avs_writedata[7:0] & `TPS_CTL_MASK;
			end
			if (wr_lane0 && avs_address == `TPS_ADDR_CORE_IRQ) begin
				core_irq_reg <= avs_writedata[7:0];
			end
			if (wr_lane0 && avs_address == `TPS_ADDR_PIE_ONE) begin
				pie_one_reg <= avs_writedata[7:0];
			end
			// Flags: read clears, write may set or clear, event wins
			if (rd_flags) begin
				pir_one_reg <= 8'h00;
			end else if (wr_lane0 && avs_address == `TPS_ADDR_PIR_ONE) begin
				pir_one_reg <= avs_writedata[7:0];
			end
			if (post_fire) begin
				pir_one_reg[`TPS_BIT_TIMER_IRQ] <= 1'b1;
			end
			// Request only with every enable set; flag sets regardless
			irq <= pir_one_reg[`TPS_BIT_TIMER_IRQ] && pie_one_reg[`TPS_BIT_TIMER_IRQ]
				&& core_irq_reg[`TPS_BIT_PERIPHERAL_IRQ_ENABLE] && core_irq_reg[`TPS_BIT_GIE];
		end
	end
endmodule // tps_timer
